// File: mac_serial_ports.sv
// Serial-side ports of a 10 Mbit/s MAC: external address detect port and
// general purpose serial port, with their pin sharing and control registers.
// Assumes clk at 10 MHz (one bit time), a decoder on the same clock giving one
// strobe per bit, and a MAC core that supplies the full transmit bit stream.
// Function
// R1: Address detect port works only when select bit 3 of bus config two is set.
// R2: Frame reject is internal reject OR the low-active external reject input.
// R3: Delimiter rises on start-of-frame delimiter; data output then carries the frame.
// R4: Delimiter stays high four bit times (400 ns) after second SFD one.
// R5: Delimiter then toggles every 400 ns; each rise marks a byte's first bit.
// R6: Delimiter stays low while a frame is being transmitted.
// R7: Decoded NRZ data appears on receive data output with its bit clock.
// R8: Twisted pair: outputs move only on receive; AUI: on transmit and receive.
// R9: Serial port chosen by port select, enabled by test shadow bit or core test.
// R10: Host limits slave decode to 24 address bits before serial test mode; the code ignores aw24 and compares all 32 bits outside serial mode.
// R11: In serial mode the upper 8 address bits always count as matched.
// R12: In serial mode the upper 8 address bits are never driven as master.
// R13: Transmit data output carries preamble, SFD, data and FCS.
// R14: Transmit enable high for every valid bit; partner ignores data otherwise.
// R15: Partner's transmit clock paces transmit; data valid at its rising edges.
// R16: Partner's collision input is the device's collision indication.
// R17: Receive data sampled at receive clock rises only while carrier is high.
// R18: Serial signals share address pins 31 down to 25 in documented order.
// R19: Reject shares IRQ2; delimiter, data, clock share LED_ONE_PIN, LED pre-3, LED_TWO_PIN.
// R20: Bit time is 100 ns, half of the 20 MHz reference.
// R21: Delimiter held low after reset and while detect port is disabled.
//
// The placing of the registers and strobed register access were decided locally.
`include "mac_serial_map.svh"

module mac_serial_ports
    import mac_serial_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        dec_bit,
    input  wire logic        dec_stb,
    input  wire logic        rx_active,
    input  wire logic        tx_active,
    input  wire logic        int_reject,
    input  wire logic        mac_tx_bit,
    input  wire logic        mac_tx_valid,
    output logic             mac_tx_take,
    output logic             frame_reject,
    output logic             coll_ind,
    input  wire logic [31:0] slv_addr,
    input  wire logic [31:0] io_base,
    input  wire logic        slv_valid,
    output logic             io_hit,
    input  wire logic [7:0]  mst_addr_hi,
    input  wire logic        mst_addr_oe,
    input  wire logic [7:0]  addr_pin_in,
    output logic      [7:0]  addr_pin_out,
    output logic      [7:0]  addr_pin_oe,
    input  wire logic        led_one_pin_func,
    input  wire logic        led_two_pin_func,
    input  wire logic        led3_func,
    output logic             led_one_pin,
    output logic             led_two_pin,
    output logic             led_pre_three_pin,
    input  wire logic        irq2_req,
    input  wire logic        irq_two_pin_in,
    output logic             irq_two_pin_out,
    output logic             irq_two_pin_oe
);
    localparam int SYNC_W = 6;
    localparam int BITS_W = 3;

    initial
    begin
        if (`BIT_CYCLES != 1 || `DELIM_HALF_BITS != 4)
            $error("bit timing must be one clock per bit, four bits per half");
    end

    // Control and status registers
    logic [31:0] bus_cfg_two_reg;
    logic [31:0] mode_reg;
    logic [31:0] bus_cfg_eighteen_reg;
    logic [31:0] test_reg;
    logic [31:0] rdata_reg;

    // Two-flop synchronisers plus one history stage for edge finding
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] hist_reg;
    wire  [SYNC_W-1:0] pins_async = {irq_two_pin_in, addr_pin_in[5:1]};

    // Receive framing state
    rx_state_t   rx_state_reg;
    rx_state_t   rx_state_next;
    logic        last_bit_reg;
    logic [BITS_W-1:0] bcnt_reg;
    logic        delim_reg;
    logic        delim_next;
    logic        srd_reg;
    logic        rx_bit_clk_reg;
    logic        reject_reg;
    logic        coll_reg;
    logic        io_hit_reg;
    logic        take_reg;
    logic [7:0]  pin_out_reg;
    logic [7:0]  pin_oe_reg;
    logic        led_one_pin_reg;
    logic        led_two_pin_reg;
    logic        led3_reg;
    logic        irq2_reg;
    logic        irq2_oe_reg;
    logic        gp_serial_port_reg;

    // Register write decode and mode selection
    wire wr_bus_cfg_two  = reg_wr && reg_addr == `OFS_BUS_CFG_TWO;
    wire wr_mode  = reg_wr && reg_addr == `OFS_MODE_REG;
    wire wr_bus_cfg_eighteen = reg_wr && reg_addr == `OFS_BUS_CFG_18;
    wire wr_test  = reg_wr && reg_addr == `OFS_TEST_CTL_REG;
    wire ext_addr_detect_port_on  = bus_cfg_two_reg[`BIT_EXT_DET_SEL];  // R1
    wire port_sel_t psel = port_sel_t'(mode_reg[`POS_PORT_SEL +: 2]);
    wire test_on  = bus_cfg_eighteen_reg[`BIT_TEST_SHADOW1] | test_reg[`BIT_CORE_TEST];
    wire gp_serial_port_on  = psel == PSEL_GP_SERIAL_PORT && test_on;  // R9
    wire aw24     = bus_cfg_two_reg[`BIT_IO_AW24];

    // Synchronised pin views; pin order follows address pins 25..29, then IRQ2
    wire rxd_s    = sync2_reg[0];  // R18
    wire rxclk_s  = sync2_reg[1];
    wire crs_s    = sync2_reg[2];
    wire coll_s   = sync2_reg[3];
    wire txclk_s  = sync2_reg[4];
    wire rej_n_s  = sync2_reg[5];  // R19
    wire rxclk_up = rxclk_s & ~hist_reg[1];
    wire txclk_dn = ~txclk_s & hist_reg[4];

    // Unified bit source: serial port pins or internal decoder
    wire g_stb    = rxclk_up & crs_s;  // R17
    wire bit_stb  = gp_serial_port_on ? g_stb : dec_stb;
    wire bit_val  = gp_serial_port_on ? rxd_s : dec_bit;
    wire carrier  = gp_serial_port_on ? crs_s : rx_active;
    wire show_ok  = carrier | (psel == PSEL_AUI & tx_active);  // R8
    wire sfd_hit  = rx_state_reg == RX_PRE & bit_stb & bit_val & last_bit_reg;
    wire [BITS_W-1:0] bcnt_inc = bcnt_reg + 3'h1;

    // Address decode, upper byte forced matched in serial mode
    wire lo_match = slv_addr[23:0] == io_base[23:0];
    wire hi_match = slv_addr[31:24] == io_base[31:24];
    wire hit_now  = slv_valid & lo_match & (gp_serial_port_on | hi_match);  // R11

    // Read mux
    wire [31:0] status_w = {28'h0, coll_reg, gp_serial_port_on,
                            rx_state_reg == RX_FRAME, reject_reg};
    wire [31:0] rd_mux =
        reg_addr == `OFS_BUS_CFG_TWO  ? bus_cfg_two_reg  :
        reg_addr == `OFS_MODE_REG     ? mode_reg  :
        reg_addr == `OFS_BUS_CFG_18   ? bus_cfg_eighteen_reg :
        reg_addr == `OFS_TEST_CTL_REG ? test_reg  :
        reg_addr == `OFS_STATUS_REG   ? status_w  : 32'h0;

    // Address pins: serial port signals or master address; on entry to serial
    // mode the held bits start at 0 so no stale master address looks like an enable
    wire [7:0] pin_out_next = gp_serial_port_on ?
        {(txclk_dn ? mac_tx_bit : pin_out_reg[7] & gp_serial_port_reg),
         (txclk_dn ? mac_tx_valid : pin_out_reg[6] & gp_serial_port_reg), 6'h0} :
        mst_addr_hi;  // R13 R14 R15
    wire [7:0] pin_oe_next = gp_serial_port_on ? `GP_SERIAL_PORT_OE_PATTERN :
        {8{mst_addr_oe}};  // R12

    // Receive framing: hunt preamble, find the SFD's second one, track bytes
    always_comb
    begin
        rx_state_next = rx_state_reg;
        case (rx_state_reg)
            RX_IDLE:
                if (carrier && bit_stb && !tx_active)
                    rx_state_next = RX_PRE;
            RX_PRE:
                if (!carrier || tx_active)
                    rx_state_next = RX_IDLE;
                else if (sfd_hit)
                    rx_state_next = RX_FRAME;  // R3
            RX_FRAME:
                if (!carrier || tx_active)
                    rx_state_next = RX_IDLE;
            default:
                rx_state_next = RX_IDLE;
        endcase
    end

    // Delimiter: four bits high, four low, rising at each byte start
    always_comb
    begin
        delim_next = delim_reg;
        if (!ext_addr_detect_port_on || tx_active || !carrier)
            delim_next = 1'b0;  // R6 R21
        else if (sfd_hit)
            delim_next = 1'b1;  // R4
        else if (rx_state_reg == RX_FRAME && bit_stb)
            delim_next = ~bcnt_inc[2];  // R5
    end

    // Control registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_cfg_two_reg  <= `RST_BUS_CFG_TWO;
            mode_reg  <= `RST_MODE_REG;
            bus_cfg_eighteen_reg <= `RST_BUS_CFG_18;
            test_reg  <= `RST_TEST_CTL_REG;
            rdata_reg <= 32'h0;
        end
        else
        begin
            if (wr_bus_cfg_two)
                bus_cfg_two_reg <= reg_wdata;
            if (wr_mode)
                mode_reg <= reg_wdata;
            if (wr_bus_cfg_eighteen)
                bus_cfg_eighteen_reg <= reg_wdata;
            if (wr_test)
                test_reg <= reg_wdata;
            rdata_reg <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_reg <= {SYNC_W{1'b0}};
            sync2_reg <= {SYNC_W{1'b0}};
            hist_reg  <= {SYNC_W{1'b0}};
        end
        else
        begin
            sync1_reg <= pins_async;
            sync2_reg <= sync1_reg;
            hist_reg  <= sync2_reg;
        end
    end

    // Receive state, bit count and detect-port data and clock
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_state_reg <= RX_IDLE;
            last_bit_reg <= 1'b0;
            bcnt_reg     <= 3'h0;
            delim_reg    <= 1'b0;
            srd_reg      <= 1'b0;
            rx_bit_clk_reg   <= 1'b0;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            delim_reg    <= delim_next;
            if (bit_stb)
                last_bit_reg <= bit_val;
            if (sfd_hit)
                bcnt_reg <= 3'h0;
            else if (bit_stb)
                bcnt_reg <= bcnt_inc;
            if (bit_stb && show_ok)
                srd_reg <= bit_val;  // R7 R8
            rx_bit_clk_reg <= bit_stb && show_ok;  // R7
        end
    end

    // Reject, collision, address hit and transmit handshake
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reject_reg <= 1'b0;
            coll_reg   <= 1'b0;
            io_hit_reg <= 1'b0;
            take_reg   <= 1'b0;
        end
        else
        begin
            reject_reg <= int_reject | (ext_addr_detect_port_on & ~rej_n_s);  // R2
            coll_reg   <= gp_serial_port_on & coll_s;  // R16
            io_hit_reg <= hit_now;  // R10
            take_reg   <= gp_serial_port_on & txclk_dn;  // R15
        end
    end

    // Shared pins: address bits, LEDs and second interrupt
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_out_reg <= 8'h00;
            pin_oe_reg  <= 8'h00;
            led_one_pin_reg    <= 1'b0;
            led_two_pin_reg    <= 1'b0;
            led3_reg    <= 1'b0;
            irq2_reg    <= 1'b0;
            irq2_oe_reg <= 1'b0;
            gp_serial_port_reg    <= 1'b0;
        end
        else
        begin
            gp_serial_port_reg    <= gp_serial_port_on;  // R14
            pin_out_reg <= pin_out_next;  // R18
            pin_oe_reg  <= pin_oe_next;
            led_one_pin_reg    <= ext_addr_detect_port_on ? delim_reg : led_one_pin_func;  // R19
            led_two_pin_reg    <= ext_addr_detect_port_on ? rx_bit_clk_reg : led_two_pin_func;
            led3_reg    <= ext_addr_detect_port_on ? srd_reg : led3_func;
            irq2_reg    <= irq2_req;
            irq2_oe_reg <= ~ext_addr_detect_port_on;
        end
    end

    assign reg_rdata         = rdata_reg;
    assign mac_tx_take       = take_reg;
    assign frame_reject      = reject_reg;
    assign coll_ind          = coll_reg;
    assign io_hit            = io_hit_reg;
    assign addr_pin_out      = pin_out_reg;
    assign addr_pin_oe       = pin_oe_reg;
    assign led_one_pin       = led_one_pin_reg;
    assign led_two_pin       = led_two_pin_reg;
    assign led_pre_three_pin = led3_reg;
    assign irq_two_pin_out   = irq2_reg;
    assign irq_two_pin_oe    = irq2_oe_reg;

    // Checks on the port behaviour
    ext_addr_detect_port_off_a: assert property (@(posedge clk) disable iff (!nrst) // R21
        !ext_addr_detect_port_on |=> ##1 !delim_reg || $past(ext_addr_detect_port_on))
        else $error("delimiter active with detect port off");
    led_share_a: assert property (@(posedge clk) disable iff (!nrst) // R1
        !ext_addr_detect_port_on |=> led_one_pin == $past(led_one_pin_func))
        else $error("LED_ONE_PIN pin not returned to LED use");
    reject_or_a: assert property (@(posedge clk) disable iff (!nrst) // R2
        ext_addr_detect_port_on && !rej_n_s |=> frame_reject)
        else $error("external reject not merged");
    sfd_delim_a: assert property (@(posedge clk) disable iff (!nrst) // R4
        sfd_hit && ext_addr_detect_port_on && carrier && !tx_active |=> delim_reg)
        else $error("delimiter not raised after SFD");
    delim_tx_a: assert property (@(posedge clk) disable iff (!nrst) // R6
        tx_active |=> !delim_reg)
        else $error("delimiter active during transmit");
    gp_serial_port_oe_a: assert property (@(posedge clk) disable iff (!nrst) // R12
        gp_serial_port_on |=> addr_pin_oe == `GP_SERIAL_PORT_OE_PATTERN)
        else $error("upper address driven in serial mode");
    io_hit_a: assert property (@(posedge clk) disable iff (!nrst) // R11
        gp_serial_port_on && slv_valid && lo_match |=> io_hit)
        else $error("upper byte not treated as matched");
    tx_en_a: assert property (@(posedge clk) disable iff (!nrst) // R14
        gp_serial_port_on && txclk_dn |=> addr_pin_out[6] == $past(mac_tx_valid))
        else $error("transmit enable not following valid bits");
    rx_crs_a: assert property (@(posedge clk) disable iff (!nrst) // R17
        gp_serial_port_on && !crs_s |-> !bit_stb)
        else $error("receive sampled without carrier");
    tp_quiet_a: assert property (@(posedge clk) disable iff (!nrst) // R8
        psel == PSEL_TP && !gp_serial_port_on && !rx_active |=> !rx_bit_clk_reg)
        else $error("bit clock moved outside receive");
endmodule // mac_serial_ports

// File: mac_serial_map.svh
// Offsets, field positions, reset values and timing counts of the serial ports.
// Assumes byte addresses on an 8-bit register port, one word per register.
`ifndef MAC_SERIAL_MAP_SVH
`define MAC_SERIAL_MAP_SVH
`define OFS_BUS_CFG_TWO   8'h00
`define OFS_MODE_REG      8'h04
`define OFS_BUS_CFG_18    8'h08
`define OFS_TEST_CTL_REG  8'h0c
`define OFS_STATUS_REG    8'h10
`define BIT_IO_AW24       0
`define BIT_EXT_DET_SEL   3
`define POS_PORT_SEL      7
`define BIT_TEST_SHADOW1  2
`define BIT_CORE_TEST     4
`define RST_BUS_CFG_TWO   32'h0000_0000
`define RST_MODE_REG      32'h0000_0000
`define RST_BUS_CFG_18    32'h0000_0000
`define RST_TEST_CTL_REG  32'h0000_0000
`define CLK_PERIOD_NS     100
`define REF_CLK_MHZ       20
`define BIT_TIME_NS       (2000 / `REF_CLK_MHZ)
`define BIT_CYCLES        ((`BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELIM_HALF_NS     400
`define DELIM_HALF_BITS   (`DELIM_HALF_NS / `BIT_TIME_NS)
`define GP_SERIAL_PORT_OE_PATTERN   8'hc0
`endif

// File: mac_serial_pkg.sv
// Types shared by the serial-side port logic.
// Assumes mac_serial_map.svh supplies all numbers.
package mac_serial_pkg;
    typedef enum logic [1:0] {
        PSEL_AUI  = 2'b00,
        PSEL_TP   = 2'b01,
        PSEL_GP_SERIAL_PORT = 2'b10,
        PSEL_RSVD = 2'b11
    } port_sel_t;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_PRE   = 2'b01,
        RX_FRAME = 2'b10
    } rx_state_t;
endpackage

// File: serial_pin_partner.sv
// Model of the external encoder/decoder on the shared upper address pins.
// Assumes the bench calls its tasks; both link clocks stand still outside frames.
module serial_pin_partner (
    output logic      tx_clk,
    output logic      rx_clk,
    output logic      rx_data,
    output logic      carrier,
    output logic      collision,
    input  wire logic coll_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        tx_clk  = 1'b0;
        rx_clk  = 1'b0;
        rx_data = 1'b0;
        carrier = 1'b0;
    end
    // Collision pin follows the bench's request
    assign collision = coll_req;
    // Transmit clock for n periods; the block's bit is taken at each rise
    task automatic run_tx(input int n);
        repeat (n)
        begin
            #400 tx_clk = 1'b1;
            #400 tx_clk = 1'b0;
        end
    endtask
    // Receive frame: data changes at the fall, valid at the rise under carrier
    task automatic send_rx(input logic [15:0] d, input int n);
        carrier = 1'b1;
        for (int k = 0; k < n; k++)
        begin
            rx_data = d[k];
            #400 rx_clk = 1'b1;
            #400 rx_clk = 1'b0;
        end
        carrier = 1'b0;
        rx_data = ~rx_data; // Released line must not keep the last bit
    endtask
endmodule // serial_pin_partner

// File: test_mac_serial_ports.sv
// Self-checking bench for the MAC serial-side ports.
// Assumes the partner model drives the serial pins; the bench plays core and host.
`include "mac_serial_map.svh"
module test_mac_serial_ports;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, dec_bit = 0, dec_stb = 0;
    logic        rx_active = 0, tx_active = 0, int_reject = 0, mac_tx_bit = 0, mac_tx_valid = 0;
    logic        slv_valid = 1, mst_addr_oe = 1, led_one_pin_func = 0, led_two_pin_func = 0, led3_func = 0;
    logic        irq2_req = 0, irq_two_pin_in = 1, coll_req = 0, look = 0, rd_seen = 0, rx_watch = 0;
    logic        last = 0, mac_tx_take, frame_reject, coll_ind, io_hit, led_one_pin, led_two_pin;
    logic        led_pre_three_pin, irq_two_pin_out, irq_two_pin_oe, p_txc, p_rxc, p_rxd, p_crs, p_col;
    logic [7:0]  reg_addr = 0, mst_addr_hi = 8'h5a, addr_pin_in, addr_pin_out, addr_pin_oe;
    logic [31:0] reg_wdata = 0, reg_rdata, obs, d;
    logic [31:0] io_base = 32'h0000_0300, slv_addr = 32'h7700_0300;
    logic [31:0] exp_q[$], msk_q[$];
    logic        txq[$], rxq[$];
    int          kind_q[$];
    int          mismatches = 0, total_checks = 0;
    logic [7:0]  offs[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
    logic [31:0] msk[5] = '{32'h9, 32'h180, 32'h4, 32'h10, 32'hffff_ffff};
    always #50 clk = ~clk;
    // Shared pins: the block drives where enabled, the partner elsewhere
    assign addr_pin_in = (addr_pin_oe & addr_pin_out) | (~addr_pin_oe & {2'b00, p_txc, p_col, p_crs, p_rxc, p_rxd, 1'b0});
    mac_serial_ports mac_serial_ports_inst (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .dec_bit, .dec_stb, .rx_active, .tx_active, .int_reject, .mac_tx_bit, .mac_tx_valid, .mac_tx_take,
        .frame_reject, .coll_ind, .slv_addr, .io_base, .slv_valid, .io_hit, .mst_addr_hi, .mst_addr_oe,
        .addr_pin_in, .addr_pin_out, .addr_pin_oe, .led_one_pin_func, .led_two_pin_func, .led3_func, .led_one_pin,
        .led_two_pin, .led_pre_three_pin, .irq2_req, .irq_two_pin_in, .irq_two_pin_out, .irq_two_pin_oe);
    serial_pin_partner serial_pin_partner_inst (.tx_clk(p_txc), .rx_clk(p_rxc), .rx_data(p_rxd),
        .carrier(p_crs), .collision(p_col), .coll_req(coll_req));
    task automatic print_verdict();
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic void note(input int k, input logic [31:0] e, input logic [31:0] m);
        kind_q.push_back(k);
        exp_q.push_back(e);
        msk_q.push_back(m);
    endfunction
    always @(posedge clk) rd_seen <= reg_rd;
    // Compare the oldest note with what the block shows in this cycle
    always @(negedge clk)
        if (rd_seen || look)
        begin
            case (kind_q[0])
                0: obs = reg_rdata;
                1: obs = {frame_reject, irq_two_pin_oe, irq_two_pin_out, led_one_pin, led_two_pin, led_pre_three_pin};
                2: obs = {led_one_pin, led_two_pin, led_pre_three_pin};
                3: obs = {io_hit, addr_pin_oe, addr_pin_out[5:0]};
                default: obs = {31'h0, coll_ind};
            endcase
            check($sformatf("kind %0d", kind_q.pop_front()), obs & msk_q.pop_front(), exp_q.pop_front());
        end
    // Partner view: a bit is taken at each transmit clock rise while enable is high
    always @(posedge p_txc)
        if (addr_pin_out[6] === 1'b1)
            check("tx bit", {31'h0, addr_pin_out[7]}, {31'h0, txq.pop_front()});
    // Received serial bits as shown on the detect port
    always @(negedge clk)
        if (rx_watch && led_two_pin === 1'b1)
            check("rx bit", {31'h0, led_pre_three_pin}, {31'h0, rxq.pop_front()});
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        note(0, e, m);
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask
    task automatic look_at(input int k, input logic [31:0] e, input logic [31:0] m);
        repeat (4) @(posedge clk);
        note(k, e, m);
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask
    task automatic await_take();
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
            if (n > 40)
            begin
                mismatches++;
                print_verdict();
            end
        end
        while (mac_tx_take !== 1'b1);
        @(posedge clk);
    endtask
    // Frame of preamble, delimiter and two bytes on the decoder strobe, one per cycle
    task automatic frame(input logic tp, input logic rx, input logic tx);
        logic [23:0] b;
        b = {16'($urandom), 8'hd5};
        wr(`OFS_MODE_REG, {23'h0, 1'b0, tp, 7'h0});
        for (int i = 0; i < 26; i++)
        begin
            @(posedge clk);
            dec_stb   <= (i < 24);
            dec_bit   <= b[i % 24];
            rx_active <= rx;
            tx_active <= tx;
            look      <= (i >= 2);
            if (i >= 2 && (rx | tx & !tp))
                last = b[i - 2];
            if (i >= 2)
                note(2, {29'h0, rx & !tx & (i >= 9) & (((i - 9) / 4) % 2 == 0), rx | tx & !tp, last}, 32'h7);
        end
        @(posedge clk);
        look      <= 1'b0;
        rx_active <= 1'b0;
        tx_active <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial
    begin
        void'($urandom(45391));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, then masked read-back and an unmapped place
        for (int k = 0; k < 5; k++)
            rd(offs[k], 32'h0, 32'hffff_ffff);
        for (int k = 0; k < 5; k++)
        begin
            d = $urandom;
            wr(offs[k], d);
            rd(offs[k], (k == 4) ? 32'h0 : d & msk[k], msk[k]);
        end
        wr(`OFS_MODE_REG, 32'h0);
        // Reject combining, pin sharing and idle delimiter, detect port off and on
        for (int k = 0; k < 16; k++)
        begin
            d = $urandom;
            wr(`OFS_BUS_CFG_TWO, {28'h0, k[3], 3'h0});
            int_reject <= k[0];
            irq_two_pin_in <= k[1];
            irq2_req <= k[2];
            {led_one_pin_func, led_two_pin_func, led3_func} <= d[2:0];
            look_at(1, {26'h0, k[0] | k[3] & !k[1], !k[3], k[2], k[3] ? 3'h0 : d[2:0]}, k[3] ? 32'h3e : 32'h3f);
        end
        frame(1'b0, 1'b1, 1'b0);
        frame(1'b1, 1'b1, 1'b1);
        frame(1'b0, 1'b0, 1'b1);
        frame(1'b1, 1'b0, 1'b1);
        wr(`OFS_BUS_CFG_TWO, 32'h9);
        // Serial port enable sources and the upper address pins
        for (int k = 0; k < 4; k++)
        begin
            wr(`OFS_BUS_CFG_18, {29'h0, k[0], 2'h0});
            wr(`OFS_TEST_CTL_REG, {27'h0, k[1], 4'h0});
            wr(`OFS_MODE_REG, 32'h100);
            look_at(3, (k == 0) ? {17'h0, 9'h0ff, 6'h0} : {17'h0, 9'h1c0, 6'h0}, (k == 0) ? 32'h7fc0 : 32'h7fff);
        end
        coll_req <= 1'b1;
        look_at(4, 32'h1, 32'h1);
        coll_req <= 1'b0;
        look_at(4, 32'h0, 32'h1);
        // Serial transmit: the bench feeds the core's bits on each take
        d = $urandom;
        for (int k = 0; k < 8; k++)
            txq.push_back(d[k]);
        mac_tx_bit   <= d[0];
        mac_tx_valid <= 1'b1;
        #53;
        fork
            serial_pin_partner_inst.run_tx(10);
            for (int k = 1; k <= 8; k++)
            begin
                await_take();
                mac_tx_bit   <= d[k % 8];
                mac_tx_valid <= (k < 8);
            end
        join
        check("tx count", txq.size(), 32'h0);
        // Serial receive under carrier
        @(posedge clk);
        rx_active <= 1'b1;
        rx_watch  <= 1'b1;
        for (int k = 0; k < 12; k++)
            rxq.push_back(d[k + 8]);
        #53;
        serial_pin_partner_inst.send_rx(d[23:8], 12);
        repeat (6) @(posedge clk);
        rx_watch <= 1'b0;
        check("rx count", rxq.size(), 32'h0);
        print_verdict();
    end
endmodule // test_mac_serial_ports
